//--- logic/hbpgc_regs.svh
`ifndef HBPGC_REGS_SVH
`define HBPGC_REGS_SVH
`define HB_CLK_MHZ 40
`define HB_MINPULSE_NS 2500
`define HB_LSPULSE_US 200
`define HB_OFF_CTRL 8'h00
`define HB_OFF_CFG 8'h04
`define HB_OFF_CMD 8'h08
`define HB_OFF_STAT 8'h0C
`define HB_OFF_CUR0 8'h10
`define HB_OFF_CUR5 8'h24
`define HB_CTRL_W 12
`define HB_CTRL_RST 12'h000
`define HB_CFG_RST 6'h00
`define HB_CTRL_REL_LSB 0
`define HB_CTRL_FILT_LSB 3
`define HB_CTRL_EVT_BIT 5
`define HB_CTRL_RATE_LSB 6
`define HB_CTRL_CUT_LSB 9
`define HB_CFG_START_LSB 0
`define HB_CFG_DEF_LSB 3
`define HB_CMD_START_BIT 0
`define HB_CMD_DEF_BIT 1
`define HB_STAT_LOCK_LSB 3
`define HB_STAT_RAW_LSB 6
`define HB_STAT_STRETCH_LSB 15
`define HB_FILT_BYP 2'h0
`define HB_FILT_CIC 2'h1
`define HB_FILT_IIR 2'h2
`define HB_SR_BASE 16'h0028
`define HB_CIC_LG_MAX 3'h4
`define HB_IIR_FRAC 8
`define HB_IIR_KMAX 4'h8
`endif

//--- logic/hbpgc_pkg.sv
package hbpgc_pkg;
  typedef enum logic [1:0] {HBPGC_BLOCKED, HBPGC_LSPULSE, HBPGC_RUN, HBPGC_FAULT} hbpgc_grp_e;
  typedef logic signed [23:0] hbpgc_acc_t;
endpackage

//--- logic/hbpgc_top.sv
// Operation
// [RULE1] one fault monitor per pair, reported
// [RULE2] pair fault switches both stages off
// [RULE3] stage n driven only by channel n
// [RULE4] gate command equals channel signal outside run; in run a new level waits until the last one has stood MIN_PULSE_CYC cycles
// [RULE5] released stage: exactly one switch on
// [RULE6] one release per pair of stages
// [RULE7] release always acts on both stages
// [RULE8] blocked off; drive0 high-side; drive1 low-side
// [RULE9] power-on: all stages blocked, both off
// [RULE10] each release edge: low-side on 200 us
// [RULE11] start and default release values applied
// [RULE12] 14-bit current sample at configured rate
// [RULE13] one sampling rate for six channels
// [RULE14] shared CIC, IIR or bypass path
// [RULE15] event mode forces the filter off
// [RULE16] CIC decimation derived from sampling rate
// [RULE17] second-order IIR, rate dependent cutoff
// [RULE18] measured current readable by software
// [RULE19] released drive pulses stretched to 2.5 us
// [RULE20] fault lockout until blocked and released again
`timescale 1ns/1ps
`include "hbpgc_regs.svh"
module hbpgc_top
  import hbpgc_pkg::*;
#(
  parameter int ADC_W = 14,
  parameter int MIN_PULSE_NS = `HB_MINPULSE_NS,
  parameter int MIN_PULSE_CYC = (MIN_PULSE_NS * `HB_CLK_MHZ + 999) / 1000,
  parameter int LS_PULSE_CYC = `HB_LSPULSE_US * `HB_CLK_MHZ
)
(
  input wire logic pclk, // module clock
  input wire logic presetn, // async reset, low active
  input wire logic ce, // clock enable, freezes all state
  input wire logic psel, // apb select
  input wire logic penable, // apb enable
  input wire logic pwrite, // apb direction
  input wire logic [7:0] paddr, // apb byte address
  input wire logic [31:0] pwdata, // apb write data
  output logic [31:0] prdata, // apb read data
  output logic pready, // apb ready
  output logic pslverr, // apb error on unmapped address
  input wire logic [5:0] stage_drive_cmd, // output channel n level, pin
  input wire logic [2:0] flt_short, // short circuit per pair, pin
  input wire logic [2:0] flt_over, // overcurrent per pair, pin
  input wire logic [2:0] flt_temp, // overtemperature per pair, pin
  input wire logic adc_valid, // converter result strobe
  input wire logic [6*ADC_W-1:0] adc_data, // six signed results
  output logic adc_req, // conversion request pulse
  output logic [5:0] power_stage_hs, // high-side gate per stage
  output logic [5:0] power_stage_ls, // low-side gate per stage
  output logic [2:0] pair_fault_monitor // fault report to diagnostics
);
  localparam int MPW = $clog2(MIN_PULSE_CYC + 1);
  localparam int LPW = $clog2(LS_PULSE_CYC + 1);
  localparam int CW = ADC_W + 4;

  if (ADC_W < 8 || ADC_W > 16 || MIN_PULSE_CYC < 1 || LS_PULSE_CYC < 1)
  begin : g_chk
    $error("hbpgc_top: unsupported parameter values");
  end

  function automatic logic [2:0] cic_lg(input logic [2:0] r);
    cic_lg = (r >= 3'h3) ? 3'h1 : `HB_CIC_LG_MAX - r;
  endfunction

  function automatic logic [3:0] iir_k(input logic [2:0] cut, input logic [2:0] r);
    logic [3:0] t;
    t = {1'b0, cut} + {2'b00, ~r[2:1]} + 4'h1;
    iir_k = (t > `HB_IIR_KMAX) ? `HB_IIR_KMAX : t;
  endfunction

  function automatic hbpgc_acc_t one_pole(input hbpgc_acc_t y, input hbpgc_acc_t x,
                                          input logic [3:0] k);
    one_pole = y + ((x - y) >>> k);
  endfunction

  // pin inputs, two-flop synchronisers
  logic [14:0] pin_s1_r;
  logic [14:0] pin_s2_r;
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pin_s1_r <= '0;
      pin_s2_r <= '0;
    end
    else if (ce)
    begin
      pin_s1_r <= {flt_temp, flt_over, flt_short, stage_drive_cmd};
      pin_s2_r <= pin_s1_r;
    end
  end
  wire logic [5:0] drv_s = pin_s2_r[5:0];
  wire logic [2:0] sc_s = pin_s2_r[8:6];
  wire logic [2:0] oc_s = pin_s2_r[11:9];
  wire logic [2:0] ot_s = pin_s2_r[14:12];
  wire logic [2:0] fault_now = sc_s | oc_s | ot_s; // RULE1

  // registers
  logic [`HB_CTRL_W-1:0] ctrl_r;
  logic [5:0] cfg_r;
  logic [2:0] sticky_r;
  logic pready_r;
  logic pslverr_r;
  logic [31:0] prdata_r;
  logic [ADC_W-1:0] cur_r [6];

  wire logic [2:0] pair_release = ctrl_r[`HB_CTRL_REL_LSB +: 3];
  wire logic [1:0] filt_sel = ctrl_r[`HB_CTRL_FILT_LSB +: 2];
  wire logic evt_mode = ctrl_r[`HB_CTRL_EVT_BIT];
  wire logic [2:0] rate_sel = ctrl_r[`HB_CTRL_RATE_LSB +: 3]; // RULE13
  wire logic [2:0] cut_sel = ctrl_r[`HB_CTRL_CUT_LSB +: 3];
  wire logic [1:0] filt_eff = evt_mode ? `HB_FILT_BYP : filt_sel; // RULE15 RULE14

  wire logic setup_acc = psel & penable & ~pready_r;
  wire logic acc = psel & penable & pready_r;
  wire logic wr = acc & pwrite;
  wire logic hit_ctrl = paddr == `HB_OFF_CTRL;
  wire logic hit_cfg = paddr == `HB_OFF_CFG;
  wire logic hit_cmd = paddr == `HB_OFF_CMD;
  wire logic hit_stat = paddr == `HB_OFF_STAT;
  wire logic hit_cur = paddr >= `HB_OFF_CUR0 && paddr <= `HB_OFF_CUR5 && paddr[1:0] == 2'h0;
  wire logic hit_any = hit_ctrl | hit_cfg | hit_cmd | hit_stat | hit_cur;
  wire logic [7:0] cur_off = paddr - `HB_OFF_CUR0;
  wire logic [2:0] cur_idx = cur_off[4:2];

  // group sequencing
  hbpgc_grp_e st_r [3];
  hbpgc_grp_e st_nxt [3];
  logic [LPW-1:0] lsp_cnt_r [3];
  logic [5:0] cmd_r;
  logic [MPW-1:0] mp_cnt_r [6];
  logic [5:0] hs_nxt;
  logic [5:0] ls_nxt;
  logic [5:0] stretch;
  logic [2:0] lock;

  always_comb
  begin
    for (int g = 0; g < 3; g++)
    begin
      st_nxt[g] = st_r[g];
      case (st_r[g])
        HBPGC_BLOCKED:
          if (fault_now[g])
            st_nxt[g] = HBPGC_FAULT; // RULE2
          else if (pair_release[g])
            st_nxt[g] = HBPGC_LSPULSE; // RULE10
        HBPGC_LSPULSE:
          if (fault_now[g])
            st_nxt[g] = HBPGC_FAULT; // RULE2
          else if (!pair_release[g])
            st_nxt[g] = HBPGC_BLOCKED;
          else if (lsp_cnt_r[g] == '0)
            st_nxt[g] = HBPGC_RUN;
        HBPGC_RUN:
          if (fault_now[g])
            st_nxt[g] = HBPGC_FAULT; // RULE2
          else if (!pair_release[g])
            st_nxt[g] = HBPGC_BLOCKED;
        HBPGC_FAULT:
          // re-arm only via a blocked phase, so a stale release cannot restart
          if (!pair_release[g] && !fault_now[g])
            st_nxt[g] = HBPGC_BLOCKED; // RULE20
        default:
          st_nxt[g] = HBPGC_BLOCKED;
      endcase
    end
  end

  always_comb
  begin
    for (int s = 0; s < 6; s++)
    begin
      // both stages of pair s/2 follow the same state
      ls_nxt[s] = st_nxt[s / 2] == HBPGC_LSPULSE ||
                  (st_nxt[s / 2] == HBPGC_RUN && cmd_r[s]); // RULE7 RULE8 RULE10
      hs_nxt[s] = st_nxt[s / 2] == HBPGC_RUN && !cmd_r[s]; // RULE5 RULE8
      stretch[s] = st_r[s / 2] == HBPGC_RUN && mp_cnt_r[s] != '0 && drv_s[s] != cmd_r[s];
    end
    for (int g = 0; g < 3; g++)
      lock[g] = st_r[g] == HBPGC_FAULT;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      for (int g = 0; g < 3; g++)
      begin
        st_r[g] <= HBPGC_BLOCKED; // RULE9
        lsp_cnt_r[g] <= '0;
      end
    end
    else if (ce)
    begin
      for (int g = 0; g < 3; g++)
      begin
        st_r[g] <= st_nxt[g]; // RULE6
        if (st_r[g] != HBPGC_LSPULSE && st_nxt[g] == HBPGC_LSPULSE)
          lsp_cnt_r[g] <= LPW'(LS_PULSE_CYC - 1); // RULE10
        else if (lsp_cnt_r[g] != '0)
          lsp_cnt_r[g] <= lsp_cnt_r[g] - 1'b1;
      end
    end
  end

  // min pulse: in run a new level is taken only once the last one has stood long enough; outside run it is taken at once
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      cmd_r <= '0;
      for (int s = 0; s < 6; s++)
        mp_cnt_r[s] <= '0;
    end
    else if (ce)
    begin
      for (int s = 0; s < 6; s++)
      begin
        if (st_r[s / 2] != HBPGC_RUN)
        begin
          cmd_r[s] <= drv_s[s]; // RULE3 RULE4
          mp_cnt_r[s] <= MPW'(MIN_PULSE_CYC - 1); // RULE19
        end
        else if (mp_cnt_r[s] == '0 && drv_s[s] != cmd_r[s])
        begin
          cmd_r[s] <= drv_s[s]; // RULE3 RULE4
          mp_cnt_r[s] <= MPW'(MIN_PULSE_CYC - 1); // RULE19
        end
        else if (mp_cnt_r[s] != '0)
          mp_cnt_r[s] <= mp_cnt_r[s] - 1'b1; // RULE19
      end
    end
  end

  logic [5:0] hs_r;
  logic [5:0] ls_r;
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      hs_r <= '0; // RULE9
      ls_r <= '0; // RULE9
    end
    else if (ce)
    begin
      hs_r <= hs_nxt;
      ls_r <= ls_nxt;
    end
  end

  // register file
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ctrl_r <= `HB_CTRL_RST;
      cfg_r <= `HB_CFG_RST;
      sticky_r <= '0;
    end
    else if (ce)
    begin
      if (wr && hit_ctrl)
        ctrl_r <= pwdata[`HB_CTRL_W-1:0];
      else if (wr && hit_cmd && pwdata[`HB_CMD_START_BIT])
        ctrl_r[`HB_CTRL_REL_LSB +: 3] <= cfg_r[`HB_CFG_START_LSB +: 3]; // RULE11
      else if (wr && hit_cmd && pwdata[`HB_CMD_DEF_BIT])
        ctrl_r[`HB_CTRL_REL_LSB +: 3] <= cfg_r[`HB_CFG_DEF_LSB +: 3]; // RULE11
      if (wr && hit_cfg)
        cfg_r <= pwdata[5:0];
      // a fault in the clearing cycle keeps its bit
      sticky_r <= (sticky_r & ~((wr && hit_stat) ? pwdata[2:0] : 3'h0)) | fault_now; // RULE1
    end
  end

  wire logic [31:0] stat_word = {11'h0, stretch, sc_s, oc_s, ot_s, lock, sticky_r};
  wire logic [31:0] rd_data =
      hit_ctrl ? {20'h00000, ctrl_r} :
      hit_cfg ? {26'h0, cfg_r} :
      hit_stat ? stat_word :
      hit_cur ? {{(32 - ADC_W){cur_r[cur_idx][ADC_W-1]}}, cur_r[cur_idx]} : // RULE18
      32'h00000000;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
      prdata_r <= '0;
    end
    else if (ce)
    begin
      pready_r <= setup_acc;
      pslverr_r <= setup_acc & ~hit_any;
      if (setup_acc && !pwrite)
        prdata_r <= rd_data;
    end
  end

  // sampling clock, common to all six channels
  logic [15:0] sr_cnt_r;
  logic adc_req_r;
  wire logic [15:0] sr_period = `HB_SR_BASE << rate_sel; // RULE13 RULE12
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      sr_cnt_r <= '0;
      adc_req_r <= 1'b0;
    end
    else if (ce)
    begin
      adc_req_r <= sr_cnt_r == '0; // RULE12
      if (sr_cnt_r == '0 || sr_cnt_r >= sr_period)
        sr_cnt_r <= sr_period - 16'h0001;
      else
        sr_cnt_r <= sr_cnt_r - 16'h0001;
    end
  end

  // digital filters
  logic [3:0] cic_cnt_r;
  logic signed [CW-1:0] cic_acc_r [6];
  hbpgc_acc_t iir1_r [6];
  hbpgc_acc_t iir2_r [6];
  wire logic [2:0] lg = cic_lg(rate_sel); // RULE16
  wire logic [3:0] kk = iir_k(cut_sel, rate_sel); // RULE17
  wire logic [3:0] cic_last = 4'((5'h01 << lg) - 5'h01); // RULE16
  wire logic cic_dump = cic_cnt_r >= cic_last;
  logic signed [ADC_W-1:0] smp [6];
  logic signed [CW-1:0] csum [6];
  hbpgc_acc_t sxs [6];
  always_comb
  begin
    for (int c = 0; c < 6; c++)
    begin
      smp[c] = adc_data[c * ADC_W +: ADC_W]; // RULE12
      csum[c] = cic_acc_r[c] + CW'(smp[c]);
      sxs[c] = hbpgc_acc_t'(smp[c]) <<< `HB_IIR_FRAC;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      cic_cnt_r <= '0;
      for (int c = 0; c < 6; c++)
      begin
        cic_acc_r[c] <= '0;
        iir1_r[c] <= '0;
        iir2_r[c] <= '0;
        cur_r[c] <= '0;
      end
    end
    else if (ce && adc_valid)
    begin
      cic_cnt_r <= cic_dump ? 4'h0 : cic_cnt_r + 4'h1;
      for (int c = 0; c < 6; c++)
      begin
        cic_acc_r[c] <= cic_dump ? '0 : csum[c];
        // two cascaded poles stand in for the bessel pair, no multiplier
        iir1_r[c] <= one_pole(iir1_r[c], sxs[c], kk); // RULE17
        iir2_r[c] <= one_pole(iir2_r[c], iir1_r[c], kk); // RULE17
        case (filt_eff)
          `HB_FILT_CIC:
            if (cic_dump)
              cur_r[c] <= ADC_W'(csum[c] >>> lg); // RULE14
          `HB_FILT_IIR:
            cur_r[c] <= ADC_W'(iir2_r[c] >>> `HB_IIR_FRAC); // RULE14
          default:
            cur_r[c] <= smp[c]; // RULE14 RULE15
        endcase
      end
    end
  end

  logic [2:0] fault_rep_r;
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      fault_rep_r <= '0;
    else if (ce)
      fault_rep_r <= sticky_r | fault_now; // RULE1
  end

  assign prdata = prdata_r;
  assign pready = pready_r;
  assign pslverr = pslverr_r;
  assign adc_req = adc_req_r;
  assign power_stage_hs = hs_r;
  assign power_stage_ls = ls_r;
  assign pair_fault_monitor = fault_rep_r;
endmodule

//--- verif/hbpgc_top_sva.sv
`timescale 1ns/1ps
module hbpgc_top_sva #(
  parameter int LS_PULSE_CYC = 20
)
(
  input wire logic pclk, // clock
  input wire logic presetn, // reset
  input wire logic psel, // apb
  input wire logic penable, // apb
  input wire logic pready, // apb
  input wire logic pslverr, // apb
  input wire logic [5:0] stage_drive_cmd, // channels
  input wire logic [2:0] flt_short, // pins
  input wire logic [2:0] flt_over, // pins
  input wire logic [2:0] flt_temp, // pins
  input wire logic [5:0] power_stage_hs, // gates
  input wire logic [5:0] power_stage_ls, // gates
  input wire logic [2:0] pair_fault_monitor // report
);
  localparam int LCW = $clog2(LS_PULSE_CYC + 1);
  logic [5:0] on;
  logic [2:0] flt;
  logic [2:0] lsp;
  assign on = power_stage_hs | power_stage_ls;
  assign flt = flt_short | flt_over | flt_temp;
  assign lsp = {&power_stage_ls[5:4], &power_stage_ls[3:2], &power_stage_ls[1:0]};
  default clocking @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  sequence s_acc;
    psel && penable && !pready;
  endsequence
  property p_no_shoot;
    (power_stage_hs & power_stage_ls) == 6'h00;
  endproperty
  property p_por;
    !$past(presetn) |-> on == 6'h00;
  endproperty
  property p_apb_ans;
    s_acc |=> pready ##1 !pready;
  endproperty
  property p_apb_err;
    pslverr |-> pready;
  endproperty
  a_no_shoot: assert property (p_no_shoot)
    else $error("both switches on");
  a_por: assert property (p_por)
    else $error("gate on after reset");
  a_apb_ans: assert property (p_apb_ans)
    else $error("ready timing");
  a_apb_err: assert property (p_apb_err)
    else $error("error without ready");
  for (genvar g = 0; g < 3; g++)
  begin : g_pair
    sequence s_flt;
      flt[g] [*5];
    endsequence
    // cycles since the pair came on, saturating
    logic [LCW-1:0] lcnt_r;
    always_ff @(posedge pclk or negedge presetn)
    begin
      if (!presetn)
        lcnt_r <= '0;
      else if (!on[2*g])
        lcnt_r <= '0;
      else if (lcnt_r != LCW'(LS_PULSE_CYC))
        lcnt_r <= lcnt_r + 1'b1;
    end
    property p_pair_same;
      on[2*g] == on[2*g+1];
    endproperty
    property p_fault_off;
      s_flt |-> !on[2*g] && !on[2*g+1];
    endproperty
    property p_fault_rep;
      s_flt |-> pair_fault_monitor[g];
    endproperty
    property p_ls_pulse;
      on[2*g] && lcnt_r < LCW'(LS_PULSE_CYC) |-> lsp[g];
    endproperty
    a_pair_same: assert property (p_pair_same)
      else $error("pair stages differ");
    a_fault_off: assert property (p_fault_off)
      else $error("gate on during fault");
    a_fault_rep: assert property (p_fault_rep)
      else $error("fault not reported");
    a_ls_pulse: assert property (p_ls_pulse)
      else $error("low side pulse short");
  end
  for (genvar s = 0; s < 6; s++)
  begin : g_stage
    property p_drive_hi;
      stage_drive_cmd[s] [*8] ##1 stage_drive_cmd[s] |-> !power_stage_hs[s];
    endproperty
    property p_min_pulse;
      $rose(power_stage_hs[s]) |-> (power_stage_hs[s] || !on[s]) [*4];
    endproperty
    a_drive_hi: assert property (p_drive_hi)
      else $error("high side on with drive 1");
    a_min_pulse: assert property (p_min_pulse)
      else $error("drive pulse too short");
  end
endmodule
bind hbpgc_top hbpgc_top_sva #(.LS_PULSE_CYC(LS_PULSE_CYC)) hbpgc_top_sva_i (
  .pclk,
  .presetn,
  .psel,
  .penable,
  .pready,
  .pslverr,
  .stage_drive_cmd,
  .flt_short,
  .flt_over,
  .flt_temp,
  .power_stage_hs,
  .power_stage_ls,
  .pair_fault_monitor
);

//--- verif/hbpgc_gdrv_model.sv
`timescale 1ns/1ps
module hbpgc_gdrv_model (
  input wire logic pclk, // clock
  input wire logic presetn, // reset
  input wire logic [5:0] power_stage_hs, // gates
  input wire logic [5:0] power_stage_ls, // gates
  input wire logic [2:0] inj, // pairs to fail
  input wire logic [1:0] kind, // 0 short 1 over 2 temp
  input wire logic slow, // late report
  output logic [2:0] flt_short, // pins
  output logic [2:0] flt_over, // pins
  output logic [2:0] flt_temp // pins
);
  logic [2:0] d1_r;
  logic [2:0] d2_r;
  logic [2:0] f;
  logic [2:0] xt;
  logic [5:0] both;
  assign both = power_stage_hs & power_stage_ls;
  // both on shorts the supply
  assign xt = {|both[5:4], |both[3:2], |both[1:0]};
  assign f = slow ? d2_r : inj;
  assign flt_short = (kind == 2'h0 ? f : 3'h0) | xt;
  assign flt_over = kind == 2'h1 ? f : 3'h0;
  assign flt_temp = kind == 2'h2 ? f : 3'h0;
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      d1_r <= 3'h0;
      d2_r <= 3'h0;
    end
    else
    begin
      d1_r <= inj;
      d2_r <= d1_r;
    end
  end
endmodule

//--- verif/hbpgc_tb_top.sv
`timescale 1ns/1ps
module hbpgc_tb_top;
  localparam int LSC = 20;
  logic pclk = 0, presetn = 0, ce = 1, psel = 0, penable = 0, pwrite = 0;
  logic [7:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata;
  logic pready, pslverr, adc_valid = 0, adc_req, gchk = 0, slow = 0;
  logic [5:0] drv = 0, hs, ls;
  logic [2:0] fs, fo, ft, pfm, inj = 0;
  logic [1:0] kind = 0;
  logic [83:0] adc = 0;
  logic [32:0] rq[$];
  logic [14:0] gq[$];
  int miscompares = 0, checks = 0;
  always #12.5 pclk = ~pclk;
  hbpgc_top #(.LS_PULSE_CYC(LSC), .MIN_PULSE_CYC(4)) hbpgc_top_i (.pclk, .presetn, .ce,
    .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .stage_drive_cmd(drv), .flt_short(fs), .flt_over(fo), .flt_temp(ft), .adc_valid,
    .adc_data(adc), .adc_req, .power_stage_hs(hs), .power_stage_ls(ls),
    .pair_fault_monitor(pfm));
  hbpgc_gdrv_model hbpgc_gdrv_model_i (.pclk, .presetn, .power_stage_hs(hs),
    .power_stage_ls(ls), .inj, .kind, .slow, .flt_short(fs), .flt_over(fo), .flt_temp(ft));
  // converter answers each request one cycle later
  always @(posedge pclk) adc_valid <= adc_req;
  task automatic chk(input string n, input logic [32:0] s, input logic [32:0] e);
    checks++;
    if (s !== e)
    begin
      miscompares++;
      $display("ERROR %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic test_done();
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'h1;
    @(posedge pclk);
    while (pready !== 1'h1 && n < 50)
    begin
      @(posedge pclk);
      n++;
    end
    if (n >= 50)
    begin
      miscompares++;
      test_done();
    end
    psel <= 1'h0;
    penable <= 1'h0;
    @(posedge pclk);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic err);
    rq.push_back({err, e});
    apb(1'h0, a, 32'h0);
  endtask
  task automatic gat(input logic [14:0] v);
    gq.push_back(v);
    gchk <= 1'h1;
    @(posedge pclk);
    gchk <= 1'h0;
  endtask
  task automatic curs();
    for (int c = 0; c < 6; c++)
      rd(8'h10 + 8'(4 * c), {{18{adc[14 * c + 13]}}, adc[14 * c +: 14]}, 1'h0);
  endtask
  task automatic per(input logic [2:0] r);
    int n;
    n = 0;
    while (adc_req !== 1'h1 && n < 400)
    begin
      @(posedge pclk);
      n++;
    end
    @(posedge pclk);
    n = 1;
    while (adc_req !== 1'h1 && n < 400)
    begin
      @(posedge pclk);
      n++;
    end
    chk("period", 33'(n), 33'(40 << r));
  endtask
  function automatic logic [14:0] run(input logic [2:0] r, input logic [5:0] d);
    logic [5:0] m;
    m = {{2{r[2]}}, {2{r[1]}}, {2{r[0]}}};
    return {3'h0, ~d & m, d & m};
  endfunction
  always @(posedge pclk)
  begin
    if (psel && penable && pready && !pwrite)
      chk("read", {pslverr, prdata}, rq.pop_front());
    if (gchk)
      chk("gates", {pfm, hs, ls}, gq.pop_front());
  end
  initial
  begin
    drv <= 6'($urandom(68));
    repeat (5) @(posedge pclk);
    presetn <= 1'h1;
    @(posedge pclk);
    gat(15'h0);
    rd(8'h00, 32'h0, 1'h0);
    rd(8'h2C, 32'h0, 1'h1);
    $display("reset test done");
    drv <= 6'($urandom);
    apb(1'h1, 8'h00, 32'h1);
    gat(15'h0003);
    repeat (LSC) @(posedge pclk);
    gat(run(3'h1, drv));
    apb(1'h1, 8'h00, 32'h7);
    repeat (LSC + 2) @(posedge pclk);
    for (int i = 0; i < 8; i++)
    begin
      drv <= 6'($urandom);
      repeat (10) @(posedge pclk);
      gat(run(3'h7, drv));
    end
    drv <= 6'h3F;
    repeat (10) @(posedge pclk);
    drv <= 6'h00;
    @(posedge pclk);
    drv <= 6'h3F;
    repeat (5) @(posedge pclk);
    gat({3'h0, 6'h3F, 6'h00});
    $display("drive test done");
    for (int k = 0; k < 3; k++)
    begin
      kind <= 2'(k);
      slow <= k[0];
      inj <= 3'h1 << k;
      repeat (8) @(posedge pclk);
      gat(run(3'h7 & ~(3'h1 << k), drv) | (15'h1 << (12 + k)));
      rd(8'h0C, (32'h9 << k) | (32'h1 << (12 - 2 * k)), 1'h0);
      inj <= 3'h0;
      repeat (8) @(posedge pclk);
      gat(run(3'h7 & ~(3'h1 << k), drv) | (15'h1 << (12 + k)));
      apb(1'h1, 8'h0C, 32'h7);
      apb(1'h1, 8'h00, 32'h7 & ~(32'h1 << k));
      apb(1'h1, 8'h00, 32'h7);
      repeat (LSC + 2) @(posedge pclk);
      gat(run(3'h7, drv));
    end
    $display("fault test done");
    apb(1'h1, 8'h04, 32'h15);
    rd(8'h04, 32'h15, 1'h0);
    apb(1'h1, 8'h00, 32'h0);
    apb(1'h1, 8'h08, 32'h1);
    rd(8'h00, 32'h5, 1'h0);
    apb(1'h1, 8'h08, 32'h2);
    apb(1'h1, 8'h28, 32'h7);
    rd(8'h00, 32'h2, 1'h0);
    rd(8'h08, 32'h0, 1'h0);
    repeat (LSC + 2) @(posedge pclk);
    gat(run(3'h2, drv));
    $display("config test done");
    adc <= 84'({$urandom, $urandom, $urandom});
    repeat (100) @(posedge pclk);
    curs();
    apb(1'h1, 8'h00, 32'h2A);
    adc <= 84'({$urandom, $urandom, $urandom});
    repeat (100) @(posedge pclk);
    curs();
    apb(1'h1, 8'h00, 32'h0A);
    per(3'h0);
    repeat (1500) @(posedge pclk);
    curs();
    apb(1'h1, 8'h00, 32'h612);
    rd(8'h00, 32'h612, 1'h0);
    apb(1'h1, 8'h00, 32'h4A);
    per(3'h1);
    repeat (1600) @(posedge pclk);
    curs();
    apb(1'h1, 8'h00, 32'h12);
    adc <= {6{14'h2000}};
    repeat (30000) @(posedge pclk);
    curs();
    $display("current test done");
    test_done();
  end
endmodule
